// File: design/ahs_axis_halt_sequencer.sv
// axis halt sequencer with classic wishbone registers
// How it works
// - execute rising edge starts a ramp down of the axis speed
// - execute falling while running changes nothing
// - new execute rising edge restarts and recaptures decel, jerk and mode
// - busy and active rise together a few cycles after start; in mode one active waits until the previous command is no longer busy
// - at standstill done rises while busy and active drop
// - done stays while execute high, clears cycles after it falls
// - takeover by another command raises aborted, drops busy and active
// - aborted holds until execute falls, then clears later
// - if execute already low, done still rises then clears shortly
// - axis state moving on start, standstill when speed reaches zero
// - the axis is not locked; another command may interrupt
// - after completion a new command may restart the axis at once
// - a fault raises error and a fault code
// - speed falls by deceleration, rate limited by jerk
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
`include "ahs_defs.svh"
module ahs_axis_halt_sequencer (
  input  wire logic        clk_i,     // 20 MHz clock
  input  wire logic        rst_i,     // synchronous reset, high
  input  wire logic [31:0] adr_i,     // wishbone address
  input  wire logic [31:0] dat_i,     // wishbone write data
  output logic      [31:0] dat_o,     // wishbone read data
  input  wire logic        we_i,      // wishbone write
  input  wire logic [3:0]  sel_i,     // wishbone byte select
  input  wire logic        cyc_i,     // wishbone cycle
  input  wire logic        stb_i,     // wishbone strobe
  output logic             ack_o,     // wishbone ack
  input  wire logic        prev_busy_i, // previous command still moving
  output logic             busy_o,    // halt executing
  output logic             active_o,  // halt controls the axis
  output logic             done_o,    // halt completed
  output logic             aborted_flag_o, // halt taken over
  output logic             error_o,   // halt faulted
  output logic [15:0]      fault_code_o, // fault code
  output logic [1:0]       axis_state_o, // axis state
  output logic [7:0]       axis_o,    // captured axis index
  output logic [31:0]      speed_o,   // commanded axis speed
  output logic             irq_o      // interrupt level
);
  ahs_pkg::ahs_state_t state;
  logic [31:0] ctrl, decel_in, jerk_in, speed_load, decel, jerk, rate, speed;
  logic [7:0]  axis_in;
  logic [2:0]  events, mask;
  logic        exec_q, mode, clr_pend;
  logic [1:0]  cnt, clr_cnt;
  logic        wr, rd, exec, rise, fall, takeover, speed_wr;

  function automatic logic [31:0] sat_sub(input logic [31:0] a, input logic [31:0] b);
    sat_sub = (a > b) ? a - b : 32'h0;
  endfunction

  assign wr       = cyc_i && stb_i && we_i && !ack_o;
  assign rd       = cyc_i && stb_i && !we_i && !ack_o;
  assign exec     = ctrl[`AHS_CTRL_EXEC];
  assign takeover = ctrl[`AHS_CTRL_TAKEOVER];
  assign speed_wr = wr && adr_i[4:0] == `AHS_REG_SPEED && sel_i == 4'hF;
  assign rise     = exec && !exec_q;
  assign fall     = !exec && exec_q;

  always_ff @(posedge clk_i)
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= cyc_i && stb_i && !ack_o;

  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      ctrl <= 32'h0;
      axis_in <= 8'h0;
      decel_in <= 32'h0;
      jerk_in <= 32'h0;
      speed_load <= 32'h0;
      mask <= 3'h0;
    end
    else if (wr)
    begin
      unique case (adr_i[4:0])
        `AHS_REG_CTRL:  ctrl <= {29'h0, dat_i[2:0]};
        `AHS_REG_AXIS:  axis_in <= dat_i[7:0];
        `AHS_REG_DECEL: decel_in <= dat_i;
        `AHS_REG_JERK:  jerk_in <= dat_i;
        `AHS_REG_SPEED: speed_load <= dat_i;
        `AHS_REG_MASK:  mask <= dat_i[2:0];
        default: ;
      endcase
    end

  always_ff @(posedge clk_i)
    if (rst_i)
      exec_q <= 1'b0;
    else
      exec_q <= exec;

  // main sequence; another command may always take over
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      state <= ahs_pkg::AHS_IDLE;
      busy_o <= 1'b0;
      active_o <= 1'b0;
      done_o <= 1'b0;
      aborted_flag_o <= 1'b0;
      error_o <= 1'b0;
      fault_code_o <= 16'h0;
      axis_o <= 8'h0;
      decel <= 32'h0;
      jerk <= 32'h0;
      mode <= 1'b0;
      cnt <= 2'h0;
    end
    else if (rise)
    begin
      // restart also from completion, no release needed
      done_o <= 1'b0;
      aborted_flag_o <= 1'b0;
      busy_o <= 1'b0;
      active_o <= 1'b0;
      axis_o <= axis_in;
      decel <= decel_in;
      jerk <= jerk_in;
      mode <= ctrl[`AHS_CTRL_MODE];
      cnt <= 2'h0;
      if (decel_in == 32'h0 || jerk_in == 32'h0 || axis_in > `AHS_AXIS_MAX)
      begin
        error_o <= 1'b1;
        fault_code_o <= (axis_in > `AHS_AXIS_MAX) ? `AHS_FAULT_AXIS : `AHS_FAULT_PARAM;
        state <= ahs_pkg::AHS_IDLE;
      end
      else
      begin
        error_o <= 1'b0;
        fault_code_o <= 16'h0;
        state <= ahs_pkg::AHS_START;
      end
    end
    else
    begin
      // flags clear a short time after execute is low
      // placed first so that a done or aborted set in the same cycle wins
      if (clr_pend && clr_cnt == 2'(`AHS_CLEAR_CYC - 1) && !exec)
      begin
        done_o <= 1'b0;
        aborted_flag_o <= 1'b0;
      end
      unique case (state)
        ahs_pkg::AHS_IDLE: ;
        ahs_pkg::AHS_START:
          if (cnt == 2'(`AHS_START_CYC - 1))
          begin
            busy_o <= 1'b1;
            // mode one waits for the previous command
            active_o <= !(mode && prev_busy_i);
            state <= (mode && prev_busy_i) ? ahs_pkg::AHS_WAIT : ahs_pkg::AHS_RAMP;
          end
          else
            cnt <= cnt + 2'h1;
        ahs_pkg::AHS_WAIT:
          if (!prev_busy_i)
          begin
            active_o <= 1'b1;
            state <= ahs_pkg::AHS_RAMP;
          end
        ahs_pkg::AHS_RAMP:
          if (speed == 32'h0)
          begin
            done_o <= 1'b1;
            busy_o <= 1'b0;
            active_o <= 1'b0;
            state <= ahs_pkg::AHS_IDLE;
          end
      endcase
      if (takeover && state != ahs_pkg::AHS_IDLE)
      begin
        aborted_flag_o <= 1'b1;
        busy_o <= 1'b0;
        active_o <= 1'b0;
        state <= ahs_pkg::AHS_IDLE;
      end
    end

  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      clr_pend <= 1'b0;
      clr_cnt <= 2'h0;
    end
    else if (exec || !(done_o || aborted_flag_o))
    begin
      clr_pend <= 1'b0;
      clr_cnt <= 2'h0;
    end
    else if (!clr_pend)
      clr_pend <= 1'b1;
    else if (clr_cnt != 2'(`AHS_CLEAR_CYC - 1))
      clr_cnt <= clr_cnt + 2'h1;

  // speed ramp: rate grows by jerk up to decel
  always_ff @(posedge clk_i)
    if (rst_i)
    begin
      speed <= 32'h0;
      rate <= 32'h0;
    end
    else if (speed_wr && state != ahs_pkg::AHS_RAMP)
    begin
      speed <= speed_load;
      rate <= 32'h0;
    end
    else if (rise)
      rate <= 32'h0;
    else if (state == ahs_pkg::AHS_RAMP)
    begin
      rate <= (rate + jerk > decel || rate + jerk < rate) ? decel : rate + jerk;
      speed <= sat_sub(speed, rate);
    end
  assign speed_o = speed;

  // axis state
  always_comb
  begin
    if (state == ahs_pkg::AHS_START || state == ahs_pkg::AHS_RAMP ||
        state == ahs_pkg::AHS_WAIT)
      axis_state_o = ahs_pkg::AHS_AX_MOVING;
    else if (speed == 32'h0)
      axis_state_o = ahs_pkg::AHS_AX_STANDSTILL;
    else
      axis_state_o = ahs_pkg::AHS_AX_OTHER;
  end

  // sticky events; an events register read clears them, a new event wins
  logic [2:0] ev_set;
  logic       ev_rd;
  // the error event is set below from the parameter check at the start edge
  assign ev_set = {1'b0, takeover && state != ahs_pkg::AHS_IDLE && !rise,
                   state == ahs_pkg::AHS_RAMP && speed == 32'h0 && !rise};
  assign ev_rd = rd && adr_i[4:0] == `AHS_REG_EVENTS;
  always_ff @(posedge clk_i)
    if (rst_i)
      events <= 3'h0;
    else
      events <= (ev_rd ? 3'h0 : events) | ev_set |
                {rise && (decel_in == 32'h0 || jerk_in == 32'h0 ||
                          axis_in > `AHS_AXIS_MAX), 2'b00};
  assign irq_o = |(events & mask);

  always_ff @(posedge clk_i)
    if (rst_i)
      dat_o <= 32'h0;
    else if (rd)
    begin
      unique case (adr_i[4:0])
        `AHS_REG_CTRL:   dat_o <= ctrl;
        `AHS_REG_AXIS:   dat_o <= {24'h0, axis_in};
        `AHS_REG_DECEL:  dat_o <= decel_in;
        `AHS_REG_JERK:   dat_o <= jerk_in;
        `AHS_REG_SPEED:  dat_o <= speed;
        `AHS_REG_STATUS: dat_o <= {fault_code_o, 8'h0, axis_state_o,
                                   error_o, aborted_flag_o, done_o, active_o, busy_o, 1'b0};
        `AHS_REG_EVENTS: dat_o <= {29'h0, events};
        `AHS_REG_MASK:   dat_o <= {29'h0, mask};
        default:         dat_o <= 32'h0;
      endcase
    end

  // handshake checks
  chk_busy_active_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(busy_o) |-> active_o || state == ahs_pkg::AHS_WAIT)
    else $error("busy rose without active");

  chk_busy_active_same: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(busy_o) && state == ahs_pkg::AHS_RAMP |-> $rose(active_o))
    else $error("active did not rise with busy");

  chk_done_drops_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(done_o) |-> !busy_o && !active_o)
    else $error("done with busy still high");

  chk_ramp_ends: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ahs_pkg::AHS_RAMP && speed == 32'h0 && !rise && !takeover
      |=> done_o && !busy_o && !active_o)
    else $error("halt did not complete at zero speed");

  chk_done_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    done_o && exec && !rise |=> done_o)
    else $error("done dropped while execute high");

  chk_abort_drops: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(aborted_flag_o) |-> !busy_o && !active_o)
    else $error("aborted with busy high");

  chk_abort_on_takeover: assert property (@(posedge clk_i) disable iff (rst_i)
    takeover && state != ahs_pkg::AHS_IDLE && !rise |=> aborted_flag_o)
    else $error("takeover did not abort");

  chk_abort_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    aborted_flag_o && !exec && !takeover |-> ##[1:6] !aborted_flag_o)
    else $error("aborted not cleared");

  chk_fall_no_effect: assert property (@(posedge clk_i) disable iff (rst_i)
    fall && busy_o && !takeover |=> busy_o || done_o)
    else $error("execute fall cancelled halt");

  chk_restart_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    rise |=> !busy_o && !done_o && !aborted_flag_o)
    else $error("restart left flags set");

  chk_restart_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    rise |=> decel == $past(decel_in) && jerk == $past(jerk_in) && mode == $past(ctrl[1]))
    else $error("restart did not capture inputs");

  // axis state, ramp, wait, error and start latency checks
  chk_start_moving: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ahs_pkg::AHS_RAMP |-> axis_state_o == ahs_pkg::AHS_AX_MOVING)
    else $error("axis not moving during ramp");

  chk_done_at_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(done_o) |-> speed == 32'h0 && axis_state_o == ahs_pkg::AHS_AX_STANDSTILL)
    else $error("done without standstill");

  chk_ramp_monotone: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ahs_pkg::AHS_RAMP && !speed_wr |=> speed <= $past(speed))
    else $error("speed rose in ramp");

  chk_ramp_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ahs_pkg::AHS_RAMP && !rise |=> rate <= decel)
    else $error("ramp rate above deceleration");

  chk_wait_no_active: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ahs_pkg::AHS_WAIT |-> !active_o)
    else $error("active while waiting for previous command");

  chk_error_code: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(error_o) |-> fault_code_o != 16'h0)
    else $error("error without fault code");

  chk_start_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    rise && !error_o && decel_in != 32'h0 && jerk_in != 32'h0
      && axis_in <= `AHS_AXIS_MAX && !takeover |-> ##3 busy_o)
    else $error("busy late after start");
endmodule

// File: design/ahs_defs.svh
// constants for the axis halt sequencer
`ifndef AHS_DEFS_SVH
`define AHS_DEFS_SVH
`define AHS_REG_CTRL      5'h00
`define AHS_REG_AXIS      5'h04
`define AHS_REG_DECEL     5'h08
`define AHS_REG_JERK      5'h0C
`define AHS_REG_SPEED     5'h10
`define AHS_REG_STATUS    5'h14
`define AHS_REG_EVENTS    5'h18
`define AHS_REG_MASK      5'h1C
`define AHS_CTRL_EXEC     0
`define AHS_CTRL_MODE     1
`define AHS_CTRL_TAKEOVER 2
`define AHS_EV_DONE       0
`define AHS_EV_ABORT      1
`define AHS_EV_ERROR      2
`define AHS_AXIS_MAX      8'h0F
`define AHS_FAULT_PARAM   16'h0001
`define AHS_FAULT_AXIS    16'h0002
`define AHS_START_CYC     2
`define AHS_CLEAR_CYC     2
`endif

// File: design/ahs_pkg.sv
// types for the axis halt sequencer
package ahs_pkg;
  typedef enum logic [1:0] {AHS_IDLE, AHS_START, AHS_RAMP, AHS_WAIT} ahs_state_t;
  typedef enum logic [1:0] {AHS_AX_STANDSTILL, AHS_AX_MOVING, AHS_AX_OTHER} ahs_axis_t;
endpackage

// File: verification/ahs_ctrl_model.sv
// model of a previous motion command that still holds the axis
`timescale 1ns/1ns
module ahs_ctrl_model #(parameter int HOLD = 12) (
  input  wire logic clk_i,      // clock
  input  wire logic rst_i,      // synchronous reset
  input  wire logic go_i,       // previous command starts
  output logic      prev_busy_o // previous command moving
);
  int cnt;
  // the previous command frees the axis after HOLD cycles
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt <= 0;
    else if (go_i)
      cnt <= HOLD;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  assign prev_busy_o = (cnt > 0);
endmodule

// File: verification/ahs_testbench.sv
// self-checking bench for the axis halt sequencer
`timescale 1ns/1ns
`include "ahs_defs.svh"
module testbench;
  logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, go, prev_busy_i;
  logic        busy_o, active_o, done_o, aborted_flag_o, error_o, irq_o;
  logic [31:0] adr_i, dat_i, dat_o, speed_o, rd;
  logic [15:0] fault_code_o;
  logic [7:0]  axis_o;
  logic [3:0]  sel_i;
  logic [1:0]  axis_state_o;
  int          bad_count, cmp_count;

  ahs_axis_halt_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .prev_busy_i(prev_busy_i), .busy_o(busy_o), .active_o(active_o), .done_o(done_o),
    .aborted_flag_o(aborted_flag_o), .error_o(error_o), .fault_code_o(fault_code_o),
    .axis_state_o(axis_state_o), .axis_o(axis_o), .speed_o(speed_o), .irq_o(irq_o));
  ahs_ctrl_model #(.HOLD(12)) peer (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
    .prev_busy_o(prev_busy_i));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task stop_test;
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wb(input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    adr_i <= {27'h0, a};
    we_i  <= w;
    dat_i <= d;
    sel_i <= 4'hF;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return busy_o;
      1: return done_o;
      2: return aborted_flag_o;
      3: return error_o;
      default: return active_o;
    endcase
  endfunction

  // bounded wait for an output level; running out counts as a mismatch
  task wait_for(input int k, input logic v);
    int n;
    n = 0;
    while (pick(k) !== v && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(pick(k), v);
  endtask

  task arm(input logic [31:0] dec, input logic [31:0] jrk, input logic [31:0] spd);
    wb(`AHS_REG_DECEL, 1'b1, dec);
    wb(`AHS_REG_JERK, 1'b1, jrk);
    wb(`AHS_REG_SPEED, 1'b1, spd);
  endtask

  task t_reset;
    wb(`AHS_REG_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    wb(`AHS_REG_AXIS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    wb(5'h1E, 1'b0, 32'h0);
    chk(rd, 32'h0);
  endtask

  task t_done;
    wb(`AHS_REG_MASK, 1'b1, 32'h1);
    arm(32'hA, 32'h2, 32'h64);
    wb(`AHS_REG_CTRL, 1'b1, 32'h1);
    wait_for(0, 1'b1);
    chk(active_o, 1'b1);
    chk(axis_state_o, 2'h1);
    repeat (3) @(posedge clk_i);
    chk(speed_o < 32'h64, 1'b1);
    wait_for(1, 1'b1);
    chk({busy_o, active_o, axis_state_o}, 4'h0);
    chk(speed_o, 32'h0);
    repeat (5) @(posedge clk_i);
    chk({done_o, irq_o}, 2'h3);
    wb(`AHS_REG_EVENTS, 1'b0, 32'h0);
    chk(rd, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    wb(`AHS_REG_CTRL, 1'b1, 32'h0);
    wait_for(1, 1'b0);
  endtask

  task t_fall;
    arm(32'h4, 32'h1, 32'hC8);
    wb(`AHS_REG_CTRL, 1'b1, 32'h1);
    wait_for(0, 1'b1);
    wb(`AHS_REG_CTRL, 1'b1, 32'h0);
    chk(busy_o, 1'b1);
    wb(`AHS_REG_CTRL, 1'b1, 32'h1);
    repeat (4) @(posedge clk_i);
    chk({busy_o, active_o}, 2'h3);
    wb(`AHS_REG_CTRL, 1'b1, 32'h0);
    wait_for(1, 1'b1);
    chk(busy_o, 1'b0);
    wait_for(1, 1'b0);
  endtask

  task t_abort;
    arm(32'h1, 32'h1, 32'h3E8);
    wb(`AHS_REG_CTRL, 1'b1, 32'h1);
    wait_for(0, 1'b1);
    wb(`AHS_REG_CTRL, 1'b1, 32'h5);
    wait_for(2, 1'b1);
    chk({busy_o, active_o}, 2'h0);
    repeat (4) @(posedge clk_i);
    chk(aborted_flag_o, 1'b1);
    wb(`AHS_REG_CTRL, 1'b1, 32'h0);
    wait_for(2, 1'b0);
  endtask

  task t_mode1;
    arm(32'hA, 32'h2, 32'h64);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    wb(`AHS_REG_CTRL, 1'b1, 32'h3);
    wait_for(0, 1'b1);
    chk({active_o, prev_busy_i}, 2'h1);
    wait_for(4, 1'b1);
    wait_for(1, 1'b1);
    wb(`AHS_REG_CTRL, 1'b1, 32'h0);
    wait_for(1, 1'b0);
  endtask

  task t_error;
    wb(`AHS_REG_EVENTS, 1'b0, 32'h0);
    wb(`AHS_REG_MASK, 1'b1, 32'h0);
    arm(32'h0, 32'h1, 32'h32);
    wb(`AHS_REG_CTRL, 1'b1, 32'h1);
    wait_for(3, 1'b1);
    chk({fault_code_o, irq_o}, 17'h2);
    wb(`AHS_REG_MASK, 1'b1, 32'h4);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wb(`AHS_REG_STATUS, 1'b0, 32'h0);
    chk({rd[31:16], rd[5]}, 17'h3);
    wb(`AHS_REG_EVENTS, 1'b0, 32'h0);
    chk(rd, 32'h4);
    wb(`AHS_REG_CTRL, 1'b1, 32'h0);
    arm(32'h4, 32'h1, 32'h32);
    wb(`AHS_REG_AXIS, 1'b1, 32'h10);
    wb(`AHS_REG_CTRL, 1'b1, 32'h1);
    repeat (6) @(posedge clk_i);
    chk(fault_code_o, 16'h2);
    chk(axis_o, 32'h10);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    stop_test;
  end

  initial
  begin
    bad_count = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    {we_i, cyc_i, stb_i, go} = 4'h0;
    adr_i = 32'h0;
    dat_i = 32'h0;
    sel_i = 4'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_done;
    t_fall;
    t_abort;
    t_mode1;
    t_error;
    stop_test;
  end
endmodule
